// ==== pkg/serial_flash_defs.vh ====
// Constants shared by the serial flash pin front end
`ifndef SERIAL_FLASH_DEFS_VH
`define SERIAL_FLASH_DEFS_VH

// ----------------------------------------------------------------
// Array organisation
// ----------------------------------------------------------------
`define PAGE_BYTES      9'h100
`define PAGE_COUNT      16'h8000
`define PAGE_IDX_W      15
`define OFFSET_W        8
`define ADDR_W          24
`define ADDR_LAST_BIT   5'h17
`define CMD_LAST_BIT    5'h07
`define DUMMY_LAST_BIT  5'h07
`define BYTE_LAST_BIT   5'h07

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define OP_READ         8'h03
`define OP_FAST_READ    8'h0b
`define OP_DUAL_READ    8'h3b
`define OP_QUAD_READ    8'h6b
`define OP_PAGE_PROG    8'h02
`define OP_ERASE_4K     8'h20
`define OP_ERASE_32K    8'h52
`define OP_ERASE_64K    8'hd8
`define OP_ERASE_CHIP   8'hc7

// ----------------------------------------------------------------
// Erase kinds, lane widths, power modes, fill value
// ----------------------------------------------------------------
`define ERASE_4K        2'h0
`define ERASE_32K       2'h1
`define ERASE_64K       2'h2
`define ERASE_CHIP      2'h3
`define LANE_1          2'h0
`define LANE_2          2'h1
`define LANE_4          2'h2
`define PWR_STANDBY     2'h0
`define PWR_ACTIVE      2'h1
`define PWR_BUSY        2'h2
`define UNDERRUN_BYTE   8'hff
`define FIFO_DEPTH      4
`define FIFO_AW         2

`endif

// ==== src/pin_sync.v ====
// Two-stage synchroniser for pins arriving from outside the mclk domain
module pin_sync #(
  parameter WIDTH     = 3,
  parameter RESET_VAL = 3'h0
) (
  input  wire             mclk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_ff;

  // Only the second stage reads the first one
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= RESET_VAL;
      dout    <= RESET_VAL;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule

// ==== src/byte_fifo.v ====
// Small flip-flop FIFO with valid/ready on both sides and a flush
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  reg             in_ready_ff;
  reg             empty_ff;
  wire            push;
  wire            pop;
  reg  [AW:0]     nxt_count;

  assign push      = in_valid & in_ready_ff;
  assign pop       = out_ready & ~empty_ff;
  assign in_ready  = in_ready_ff;
  assign out_valid = ~empty_ff;
  assign out_data  = mem_ff[rd_ptr_ff];

  always @* begin
    nxt_count = count_ff;
    if (push & ~pop)
      nxt_count = count_ff + 1'b1;
    else if (pop & ~push)
      nxt_count = count_ff - 1'b1;
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      localparam [AW-1:0] IDX = i;
      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
          mem_ff[i] <= {WIDTH{1'b0}};
        else if (push && wr_ptr_ff == IDX)
          mem_ff[i] <= in_data;
      end
    end
  endgenerate

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff    <= {(AW+1){1'b0}};
      in_ready_ff <= 1'b1;
      empty_ff    <= 1'b1;
    end else if (flush) begin
      wr_ptr_ff   <= {AW{1'b0}};
      rd_ptr_ff   <= {AW{1'b0}};
      count_ff    <= {(AW+1){1'b0}};
      in_ready_ff <= 1'b1;
      empty_ff    <= 1'b1;
    end else begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != DEPTH[AW:0]);
      empty_ff <= (nxt_count == {(AW+1){1'b0}});
    end
  end

endmodule

// ==== src/serial_flash_pin_interface.v ====
// Serial flash pin front end: chip select, serial clock, data lines, decode
`include "serial_flash_defs.vh"

module serial_flash_pin_interface (
  input  wire                   mclk,
  input  wire                   reset_n,
  input  wire                   cs_n_pin,
  input  wire                   sck_pin,
  input  wire [3:0]             io_in,
  output reg  [3:0]             io_out,
  output reg  [3:0]             io_oe_n,
  input  wire                   array_busy,
  input  wire                   rd_valid,
  output wire                   rd_ready,
  input  wire [7:0]             rd_data,
  output reg                    rd_active,
  output reg                    rd_start,
  output reg  [`PAGE_IDX_W-1:0] mem_page,
  output reg  [`OFFSET_W-1:0]   mem_offset,
  output reg                    wr_valid,
  output reg  [7:0]             wr_data,
  output reg                    prog_done,
  output reg                    erase_req,
  output reg  [1:0]             erase_kind,
  output reg  [1:0]             power_mode,
  output reg                    armed
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_CMD   = 3'h1;
  localparam ST_ADDR  = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_WDATA = 3'h5;
  localparam ST_DONE  = 3'h6;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  wire       cs_n_s;
  wire       sck_s;
  wire       io0_s;
  reg        cs_n_d_ff;
  reg        sck_d_ff;
  wire       selected;
  wire       sck_rise;
  wire       sck_fall;
  wire       cs_fall;
  wire       cs_rise;

  // Chip select history resets low: a pin already low at power-up then
  // shows no falling edge, and a pin high shows only a harmless rise.
  pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h0)
  ) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     ({cs_n_pin, sck_pin, io_in[0]}),
    .dout    ({cs_n_s, sck_s, io0_s})
  );

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_d_ff <= 1'b0;
      sck_d_ff  <= 1'b0;
    end else begin
      cs_n_d_ff <= cs_n_s;
      sck_d_ff  <= sck_s;
    end
  end

  assign selected = ~cs_n_s;
  assign sck_rise = sck_s & ~sck_d_ff;
  assign sck_fall = ~sck_s & sck_d_ff;
  assign cs_fall  = ~cs_n_s & cs_n_d_ff;
  assign cs_rise  = cs_n_s & ~cs_n_d_ff;

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire       fifo_pop;
  wire       fifo_push;

  // Bytes are taken only while the data phase is open, so a late valid
  // after deselect cannot refill the flushed buffer
  assign fifo_push = rd_valid & rd_active;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .flush     (cs_rise),
    .in_valid  (fifo_push),
    .in_ready  (rd_ready),
    .in_data   (rd_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  reg  [2:0]  state_ff;
  reg  [7:0]  cmd_ff;
  reg  [23:0] addr_ff;
  reg  [4:0]  bit_cnt_ff;
  reg  [1:0]  lane_ff;
  reg  [7:0]  shreg_ff;
  reg  [3:0]  bits_left_ff;
  reg  [8:0]  wr_count_ff;
  reg  [7:0]  wr_byte_ff;
  reg         erase_pend_ff;
  wire [7:0]  nxt_cmd;
  wire [23:0] nxt_addr;
  wire [7:0]  nxt_wr_byte;
  wire        load_byte;
  wire [7:0]  out_byte;
  reg  [3:0]  step;
  reg  [3:0]  lane_oe_n;
  reg  [3:0]  lane_bits;

  assign nxt_cmd     = {cmd_ff[6:0], io0_s};
  assign nxt_addr    = {addr_ff[22:0], io0_s};
  assign nxt_wr_byte = {wr_byte_ff[6:0], io0_s};

  // A new byte is fetched only when the previous one is fully shifted out
  assign load_byte = (state_ff == ST_RDATA) & sck_fall & (bits_left_ff == 4'h0);
  assign fifo_pop  = load_byte & selected;
  // Underrun sends a fill value rather than stalling the host clock
  assign out_byte  = load_byte ? (fifo_valid ? fifo_data : `UNDERRUN_BYTE) : shreg_ff;

  // Per-lane shift width, driven lines and bit placement
  always @* begin
    step      = 4'h1;
    lane_oe_n = 4'hd;
    lane_bits = {2'h0, out_byte[7], 1'b0};
    case (lane_ff)
      `LANE_1: begin
        step      = 4'h1;
        lane_oe_n = 4'hd;
        lane_bits = {2'h0, out_byte[7], 1'b0};
      end
      `LANE_2: begin
        step      = 4'h2;
        lane_oe_n = 4'hc;
        lane_bits = {2'h0, out_byte[7:6]};
      end
      `LANE_4: begin
        step      = 4'h4;
        lane_oe_n = 4'h0;
        lane_bits = out_byte[7:4];
      end
      default: begin
        step      = 4'h1;
        lane_oe_n = 4'hd;
        lane_bits = {2'h0, out_byte[7], 1'b0};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Power mode follows chip select and the internal busy flag
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      power_mode <= `PWR_STANDBY;
    else if (selected)
      power_mode <= `PWR_ACTIVE;
    else if (array_busy)
      power_mode <= `PWR_BUSY;
    else
      power_mode <= `PWR_STANDBY;
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff      <= ST_IDLE;
      armed         <= 1'b0;
      cmd_ff        <= 8'h00;
      addr_ff       <= 24'h000000;
      bit_cnt_ff    <= 5'h00;
      lane_ff       <= `LANE_1;
      shreg_ff      <= 8'h00;
      bits_left_ff  <= 4'h0;
      wr_count_ff   <= 9'h000;
      wr_byte_ff    <= 8'h00;
      erase_pend_ff <= 1'b0;
      io_out        <= 4'h0;
      io_oe_n       <= 4'hf;
      rd_active     <= 1'b0;
      rd_start      <= 1'b0;
      mem_page      <= {`PAGE_IDX_W{1'b0}};
      mem_offset    <= {`OFFSET_W{1'b0}};
      wr_valid      <= 1'b0;
      wr_data       <= 8'h00;
      prog_done     <= 1'b0;
      erase_req     <= 1'b0;
      erase_kind    <= `ERASE_4K;
    end else begin
      rd_start  <= 1'b0;
      wr_valid  <= 1'b0;
      prog_done <= 1'b0;
      erase_req <= 1'b0;
      if (cs_rise) begin
        // Deselect closes whatever command was under way
        state_ff      <= ST_IDLE;
        io_oe_n       <= 4'hf;
        rd_active     <= 1'b0;
        erase_pend_ff <= 1'b0;
        if (erase_pend_ff)
          erase_req <= 1'b1;
        if (state_ff == ST_WDATA && wr_count_ff != 9'h000)
          prog_done <= 1'b1;
      end else if (cs_fall) begin
        armed         <= 1'b1;
        state_ff      <= ST_CMD;
        bit_cnt_ff    <= 5'h00;
        lane_ff       <= `LANE_1;
        bits_left_ff  <= 4'h0;
        wr_count_ff   <= 9'h000;
        erase_pend_ff <= 1'b0;
      end else if (!selected) begin
        io_oe_n <= 4'hf;
      end else if (armed) begin
        if (sck_rise) begin
          case (state_ff)
            ST_CMD: begin
              cmd_ff     <= nxt_cmd;
              bit_cnt_ff <= bit_cnt_ff + 5'h01;
              if (bit_cnt_ff == `CMD_LAST_BIT) begin
                bit_cnt_ff <= 5'h00;
                case (nxt_cmd)
                  `OP_READ, `OP_FAST_READ, `OP_PAGE_PROG,
                  `OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K: begin
                    state_ff <= ST_ADDR;
                  end
                  `OP_DUAL_READ: begin
                    state_ff <= ST_ADDR;
                    lane_ff  <= `LANE_2;
                  end
                  `OP_QUAD_READ: begin
                    state_ff <= ST_ADDR;
                    lane_ff  <= `LANE_4;
                  end
                  `OP_ERASE_CHIP: begin
                    state_ff      <= ST_DONE;
                    erase_kind    <= `ERASE_CHIP;
                    erase_pend_ff <= 1'b1;
                  end
                  default: begin
                    state_ff <= ST_DONE;
                  end
                endcase
              end
            end
            ST_ADDR: begin
              addr_ff    <= nxt_addr;
              bit_cnt_ff <= bit_cnt_ff + 5'h01;
              if (bit_cnt_ff == `ADDR_LAST_BIT) begin
                bit_cnt_ff <= 5'h00;
                mem_page   <= nxt_addr[22:8];
                mem_offset <= nxt_addr[7:0];
                case (cmd_ff)
                  `OP_READ: begin
                    state_ff  <= ST_RDATA;
                    rd_start  <= 1'b1;
                    rd_active <= 1'b1;
                  end
                  `OP_FAST_READ, `OP_DUAL_READ, `OP_QUAD_READ: begin
                    state_ff <= ST_DUMMY;
                  end
                  `OP_PAGE_PROG: begin
                    state_ff <= ST_WDATA;
                  end
                  `OP_ERASE_4K: begin
                    state_ff      <= ST_DONE;
                    erase_kind    <= `ERASE_4K;
                    erase_pend_ff <= 1'b1;
                  end
                  `OP_ERASE_32K: begin
                    state_ff      <= ST_DONE;
                    erase_kind    <= `ERASE_32K;
                    erase_pend_ff <= 1'b1;
                  end
                  `OP_ERASE_64K: begin
                    state_ff      <= ST_DONE;
                    erase_kind    <= `ERASE_64K;
                    erase_pend_ff <= 1'b1;
                  end
                  default: begin
                    state_ff <= ST_DONE;
                  end
                endcase
              end
            end
            ST_DUMMY: begin
              bit_cnt_ff <= bit_cnt_ff + 5'h01;
              if (bit_cnt_ff == `DUMMY_LAST_BIT) begin
                state_ff  <= ST_RDATA;
                rd_start  <= 1'b1;
                rd_active <= 1'b1;
              end
            end
            ST_WDATA: begin
              wr_byte_ff <= nxt_wr_byte;
              bit_cnt_ff <= bit_cnt_ff + 5'h01;
              if (bit_cnt_ff == `BYTE_LAST_BIT) begin
                bit_cnt_ff <= 5'h00;
                // Bytes past one page are dropped, never written
                if (wr_count_ff < `PAGE_BYTES) begin
                  wr_valid    <= 1'b1;
                  wr_data     <= nxt_wr_byte;
                  mem_offset  <= addr_ff[7:0] + wr_count_ff[7:0];
                  wr_count_ff <= wr_count_ff + 9'h001;
                end
              end
            end
            default: begin
              bit_cnt_ff <= bit_cnt_ff;
            end
          endcase
        end
        if (sck_fall && state_ff == ST_RDATA) begin
          io_out       <= lane_bits;
          io_oe_n      <= lane_oe_n;
          shreg_ff     <= out_byte << step;
          bits_left_ff <= load_byte ? (4'h8 - step) : (bits_left_ff - step);
        end
      end
    end
  end

endmodule

// ==== verif/serial_flash_pin_props.sv ====
// Port checker of the serial flash pin front end, with its bind
`include "serial_flash_defs.vh"
module serial_flash_pin_props (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       cs_n_pin,
  input wire logic       sck_pin,
  input wire logic       array_busy,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n,
  input wire logic       rd_start,
  input wire logic       rd_active,
  input wire logic       wr_valid,
  input wire logic       prog_done,
  input wire logic       erase_req,
  input wire logic [1:0] power_mode,
  input wire logic       armed
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ----
  // Ages of sampled pin edges
  // ----
  // Saturating, so a long idle never wraps back into a window
  logic       sck_ff;
  logic       cs_ff;
  logic [3:0] fall_ff;
  logic [3:0] rise_ff;
  logic [3:0] csr_ff;
  function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
    return hit ? 4'h0 : (a == 4'hf) ? a : a + 4'h1;
  endfunction
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sck_ff  <= 1'b0;
      cs_ff   <= 1'b1;
      fall_ff <= 4'hf;
      rise_ff <= 4'hf;
      csr_ff  <= 4'hf;
    end else begin
      sck_ff  <= sck_pin;
      cs_ff   <= cs_n_pin;
      fall_ff <= age(sck_ff && !sck_pin, fall_ff);
      rise_ff <= age(!sck_ff && sck_pin, rise_ff);
      csr_ff  <= age(!cs_ff && cs_n_pin, csr_ff);
    end
  end
  // ----
  // Assertions
  // ----
  desel_hiz_a: assert property (cs_n_pin [*6] |-> io_oe_n == 4'hf) else $error("driven while deselected");
  standby_pwr_a: assert property ((cs_n_pin && !array_busy) [*6] |-> power_mode == `PWR_STANDBY)
    else $error("not in standby");
  busy_pwr_a: assert property ((cs_n_pin && array_busy) [*6] |-> power_mode == `PWR_BUSY)
    else $error("busy mode missing");
  active_pwr_a: assert property ((!cs_n_pin && armed) [*6] |-> power_mode == `PWR_ACTIVE)
    else $error("not active when selected");
  no_arm_a: assert property (!armed |-> !(rd_start || wr_valid || erase_req || prog_done))
    else $error("command before first select");
  wr_on_rise_a: assert property (wr_valid |-> rise_ff inside {[4'h0:4'h6]} && !$past(wr_valid))
    else $error("program byte not after a rise");
  out_on_fall_a: assert property ($changed(io_out) && io_oe_n != 4'hf && $past(io_oe_n) != 4'hf
    |-> fall_ff inside {[4'h0:4'h6]}) else $error("output moved off a fall");
  read_start_a: assert property (rd_start |-> ##[0:1] rd_active) else $error("read start without data phase");
  read_end_a: assert property (cs_n_pin [*6] |-> !rd_active) else $error("read outlived select");
  erase_end_a: assert property (erase_req |-> cs_n_pin && csr_ff inside {[4'h0:4'h6]})
    else $error("erase not at select rise");
  prog_end_a: assert property (prog_done |-> cs_n_pin && csr_ff inside {[4'h0:4'h6]})
    else $error("program end not at select rise");
  read_c: cover property (rd_start);
  erase_c: cover property (erase_req);
  prog_c: cover property (prog_done);
  busy_c: cover property (power_mode == `PWR_BUSY);
endmodule

bind serial_flash_pin_interface serial_flash_pin_props u_props (
  .mclk(mclk), .reset_n(reset_n), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .array_busy(array_busy),
  .io_out(io_out), .io_oe_n(io_oe_n), .rd_start(rd_start), .rd_active(rd_active), .wr_valid(wr_valid),
  .prog_done(prog_done), .erase_req(erase_req), .power_mode(power_mode), .armed(armed));

// ==== verif/spi_host_model.sv ====
// Behavioural SPI host driving the flash pins in mode 0
module spi_host_model (
  input  wire logic       mclk,
  input  wire logic [3:0] io,
  output logic            cs_n,
  output logic            sck,
  output logic            si,
  output logic            si_en
);
  timeunit 1ns;
  timeprecision 100ps;
  realtime t_next;
  // Select low at power-up, so the first command needs a fresh fall
  initial begin
    cs_n = 1'b0;
    sck = 1'b0;
    si = 1'b0;
    si_en = 1'b1;
    t_next = 0;
  end
  // Half periods run in real time: 62.5 ns rounded up to an mclk rise, so a 132 ns link clock locked to mclk
  task automatic half();
    t_next = (t_next < $realtime) ? $realtime + 62.5 : t_next + 62.5;
    while ($realtime < t_next) @(posedge mclk);
  endtask
  task automatic sel();
    half();
    cs_n <= 1'b0;
    half();
  endtask
  task automatic desel();
    half();
    cs_n <= 1'b1;
    si_en <= 1'b1;
    half();
    half();
  endtask
  task automatic tick(input logic d, output logic [3:0] q);
    si <= d;
    half();
    @(negedge mclk) q = io;
    @(posedge mclk) sck <= 1'b1;
    half();
    sck <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    logic [3:0] q;
    for (int i = 7; i >= 0; i--) tick(b[i], q);
  endtask
  task automatic addr(input logic [23:0] a);
    send(a[23:16]);
    send(a[15:8]);
    send(a[7:0]);
  endtask
  task automatic recv(input int lanes, output logic [7:0] b);
    logic [3:0] q;
    si_en <= (lanes == 1);
    for (int i = 0; i < 8 / lanes; i++) begin
      tick(1'b0, q);
      b = (lanes == 4) ? {b[3:0], q} : (lanes == 2) ? {b[5:0], q[1:0]} : {b[6:0], q[1]};
    end
  endtask
endmodule

// ==== verif/serial_flash_pin_interface_tb_top.sv ====
// Self-checking bench of the serial flash pin front end
`include "serial_flash_defs.vh"
module serial_flash_pin_interface_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, reset_n, array_busy, rd_valid, flip;
  logic        cs_n, sck, si, si_en, rd_ready, rd_active, rd_start, wr_valid, prog_done, erase_req, armed;
  logic [3:0]  io_wire, io_out, io_oe_n;
  logic [7:0]  rd_data, k, wr_data, mem_offset, wr_first, off_first, off_last;
  logic [14:0] mem_page;
  logic [1:0]  erase_kind, power_mode, kind_last;
  int          n_wr = 0, n_er = 0, n_pd = 0, n_rs = 0, bad_count = 0, checked = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) flip <= ~flip;
  // Released lines show a toggling level, never a stale one
  assign io_wire[0] = !io_oe_n[0] ? io_out[0] : si_en ? si : flip;
  assign io_wire[3:1] = (io_out[3:1] & ~io_oe_n[3:1]) | ({3{flip}} & io_oe_n[3:1]);
  spi_host_model host (.mclk(mclk), .io(io_wire), .cs_n(cs_n), .sck(sck), .si(si), .si_en(si_en));
  serial_flash_pin_interface DUT (
    .mclk(mclk), .reset_n(reset_n), .cs_n_pin(cs_n), .sck_pin(sck), .io_in(io_wire), .io_out(io_out),
    .io_oe_n(io_oe_n), .array_busy(array_busy), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_active(rd_active), .rd_start(rd_start), .mem_page(mem_page), .mem_offset(mem_offset),
    .wr_valid(wr_valid), .wr_data(wr_data), .prog_done(prog_done), .erase_req(erase_req),
    .erase_kind(erase_kind), .power_mode(power_mode), .armed(armed));
  // ----
  // Array stand-in and pulse monitor
  // ----
  // Pushes a0, a1, ... as fast as the FIFO takes them, so it fills and refuses
  always @(posedge mclk) begin
    if (rd_active !== 1'b1) begin
      rd_valid <= 1'b0;
      k <= 8'h00;
      rd_data <= 8'ha0;
    end else begin
      rd_valid <= 1'b1;
      if (rd_valid && rd_ready === 1'b1) begin
        k <= k + 8'h01;
        rd_data <= 8'ha1 + k;
      end
    end
    if (wr_valid === 1'b1 && n_wr == 0) {wr_first, off_first} <= {wr_data, mem_offset};
    if (wr_valid === 1'b1) off_last <= mem_offset;
    if (erase_req === 1'b1) kind_last <= erase_kind;
    n_wr <= n_wr + int'(wr_valid === 1'b1);
    n_er <= n_er + int'(erase_req === 1'b1);
    n_pd <= n_pd + int'(prog_done === 1'b1);
    n_rs <= n_rs + int'(rd_start === 1'b1);
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic clr();
    @(negedge mclk);
    {n_wr, n_er, n_pd, n_rs} = '0;
  endtask
  task automatic wait_pm(input logic [1:0] m);
    int n = 0;
    while (power_mode !== m && n < 40) begin
      @(negedge mclk);
      n++;
    end
    check(power_mode, m);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_arm();
    host.send(`OP_PAGE_PROG);
    host.addr(24'h000000);
    host.send(8'h11);
    host.desel();
    check(n_wr + n_pd, 0);
    check(armed, 1'b0);
    host.sel();
    wait_pm(`PWR_ACTIVE);
    check(armed, 1'b1);
    host.desel();
  endtask
  task automatic s_power();
    @(posedge mclk) array_busy <= 1'b1;
    wait_pm(`PWR_BUSY);
    @(posedge mclk) array_busy <= 1'b0;
    wait_pm(`PWR_STANDBY);
  endtask
  task automatic s_read(input logic [7:0] op, input int lanes, input logic [3:0] oe);
    logic [7:0] b;
    clr();
    host.sel();
    host.send(op);
    host.addr(24'h3456c7);
    if (op != `OP_READ) host.send(8'h00);
    for (int i = 0; i < 3; i++) begin
      host.recv(lanes, b);
      check(b, 8'ha0 + i);
    end
    @(negedge mclk);
    check(io_oe_n, oe);
    check(rd_ready, 1'b0);
    check({mem_page, mem_offset}, {15'h3456, 8'hc7});
    host.desel();
    @(negedge mclk);
    check({io_oe_n, rd_active}, {4'hf, 1'b0});
    check(n_rs, 1);
  endtask
  task automatic s_erase();
    logic [7:0] ops [4] = '{`OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K, `OP_ERASE_CHIP};
    for (int i = 0; i < 4; i++) begin
      clr();
      host.sel();
      host.send(ops[i]);
      if (i < 3) host.addr(24'h010000);
      host.desel();
      check({n_er[29:0], kind_last}, {30'd1, i[1:0]});
    end
    clr();
    host.sel();
    host.send(`OP_ERASE_4K);
    host.send(8'h01);
    host.desel();
    check(n_er, 0);
    host.send(`OP_ERASE_CHIP);
    host.sel();
    host.desel();
    check(n_er, 0);
  endtask
  task automatic s_prog();
    clr();
    host.sel();
    host.send(`OP_PAGE_PROG);
    host.addr(24'h8012fe);
    for (int i = 0; i < 257; i++) host.send(i[7:0]);
    host.desel();
    check(n_wr, 256);
    check({wr_first, off_first, off_last}, 24'h00fefd);
    check(mem_page, 15'h0012);
    check(n_pd, 1);
  endtask
  initial begin
    {mclk, reset_n, array_busy, rd_valid, flip} = 5'h00;
    {rd_data, k} = 16'ha000;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    s_arm();
    s_power();
    s_read(`OP_READ, 1, 4'hd);
    s_read(`OP_FAST_READ, 1, 4'hd);
    s_read(`OP_DUAL_READ, 2, 4'hc);
    s_read(`OP_QUAD_READ, 4, 4'h0);
    s_erase();
    s_prog();
    report_and_stop();
  end
  initial begin
    #390us;
    bad_count++;
    report_and_stop();
  end
endmodule
